// *** shared/fct_regs.vh ***
// Register map, field positions and timing constants of the fixed-cycle timer.
// Assumes inclusion by the timer top module only; definitions only.
`ifndef FCT_REGS_VH
`define FCT_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (printed offsets are not all multiples of four; byte address is index * 4)
// ----------------------------------------------------------------------------
`define FCT_IDX_PRESET_LO 8'h0B
`define FCT_IDX_PRESET_HI 8'h0C
`define FCT_IDX_EXT_CFG 8'h0D
`define FCT_IDX_FLAGS 8'h0E
`define FCT_IDX_IRQ_CTRL 8'h0F
`define FCT_IDX_CAP_HUND 8'h20
`define FCT_IDX_CAP_SEC 8'h21
`define FCT_IDX_EVT_CTRL 8'h2F
`define FCT_ADDR_W 10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FCT_EXT_RUN 4
`define FCT_EXT_SEL_HI 1
`define FCT_EXT_SEL_LO 0
`define FCT_FLG_TEVT 4
`define FCT_CTL_TIE 4
`define FCT_CTL_CLKRST 0
`define FCT_EVT_SUBRST 0
`define FCT_FLG_MASK 8'h3F
`define FCT_CTL_MASK 8'hFD
`define FCT_EVT_MASK 8'hF1
`define FCT_SEC_MASK 8'h7F

// ----------------------------------------------------------------------------
// Source encodings and timing
// ----------------------------------------------------------------------------
`define FCT_SRC_4096 2'h0
`define FCT_SRC_64 2'h1
`define FCT_SRC_SEC 2'h2
`define FCT_SRC_MIN 2'h3
`define FCT_CLK_HZ 25000000
`define FCT_REL_FAST_NS 122000
`define FCT_REL_SLOW_NS 7812500
`define FCT_RESP_OKAY 2'h0
`define FCT_RESP_SLVERR 2'h2

`endif

// *** hw/fct_timer.v ***
// Fixed-cycle countdown timer with auto-releasing open-drain interrupt,
// clock reset and event-synchronised sub-second reset, AXI4-Lite registers.
// Assumes tick strobes from the calendar core are one CLK cycle wide and
// synchronous to CLK; CE and event inputs are asynchronous pins.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "fct_regs.vh"

module fct_timer #(
  parameter CNT_W = 12,
  parameter REL_FAST_CYC = ((`FCT_CLK_HZ / 1000000) * `FCT_REL_FAST_NS) / 1000,
  parameter REL_SLOW_CYC = ((`FCT_CLK_HZ / 1000000) * `FCT_REL_SLOW_NS) / 1000
) (
  input wire CLK,
  input wire RST,
  input wire TICK_4096,
  input wire TICK_64,
  input wire TICK_SEC,
  input wire TICK_MIN,
  input wire CE_PIN,
  input wire EVENT_PIN,
  input wire [7:0] CAP_HUND_IN,
  input wire [7:0] CAP_SEC_IN,
  input wire CAP_LOAD,
  output reg INT_N_O,
  output reg INT_N_OE,
  output reg SUBSEC_CLR,
  output reg CLOCK_HALT,
  input wire [`FCT_ADDR_W-1:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [`FCT_ADDR_W-1:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);

  // Release counter width covers the slow release count at 25 MHz
  localparam REL_W = 24;

  // Register copies, timer state, synchronisers and write-channel holding flops
  reg [7:0] preset_lo_r, preset_hi_r, ext_cfg_r, flags_r, ctrl_r, evt_ctrl_r;
  reg [7:0] cap_hund_r, cap_sec_r;
  reg [CNT_W-1:0] count_r;
  reg run_d_r;
  reg [REL_W-1:0] rel_cnt_r;
  reg irq_low_r;
  reg ce_s1_r, ce_s2_r, ev_s1_r, ev_s2_r, ev_d_r;
  reg [`FCT_ADDR_W-1:0] aw_addr_r;
  reg aw_have_r, w_have_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // CE and event pins pass two flops before use
  always @(posedge CLK) begin
    if (RST) begin
      ce_s1_r <= 1'b0;
      ce_s2_r <= 1'b0;
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      ev_d_r <= 1'b0;
    end else begin
      ce_s1_r <= CE_PIN;
      ce_s2_r <= ce_s1_r;
      ev_s1_r <= EVENT_PIN;
      ev_s2_r <= ev_s1_r;
      ev_d_r <= ev_s2_r;
    end
  end

  // --------------------------------------------------------------------------
  // Timer datapath
  // --------------------------------------------------------------------------
  // Control fields decoded from the registers; event edge from the synced pin
  wire run = ext_cfg_r[`FCT_EXT_RUN];
  wire timer_irq_enable = ctrl_r[`FCT_CTL_TIE];
  wire clk_rst = ctrl_r[`FCT_CTL_CLKRST];
  wire [1:0] src = {ext_cfg_r[`FCT_EXT_SEL_HI], ext_cfg_r[`FCT_EXT_SEL_LO]};
  wire [CNT_W-1:0] preset = {preset_hi_r[3:0], preset_lo_r};
  wire evt_seen = ev_s2_r & ~ev_d_r;

  // Source select; second/minute strobes come from the calendar update itself
  reg tick_raw;
  always @* begin
    case (src)
      `FCT_SRC_4096: tick_raw = TICK_4096;
      `FCT_SRC_64: tick_raw = TICK_64;
      `FCT_SRC_SEC: tick_raw = TICK_SEC;
      default: tick_raw = TICK_MIN;
    endcase
  end
  // Clock reset halts every source but the fast one; start swallows its tick
  wire tick = tick_raw & (~clk_rst | (src == `FCT_SRC_4096));
  wire start = run & ~run_d_r;
  wire timer_evt = run & ~start & tick & (count_r == {{(CNT_W-1){1'b0}}, 1'b1});

  // Countdown with reload
  always @(posedge CLK) begin
    if (RST) begin
      count_r <= {CNT_W{1'b0}};
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= run;
      if (start)
        count_r <= preset;
      else if (timer_evt)
        count_r <= preset;
      else if (run && tick && count_r != {CNT_W{1'b0}})
        count_r <= count_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Interrupt low period and auto release
  wire [REL_W-1:0] rel_len = (src == `FCT_SRC_4096) ? REL_FAST_CYC[REL_W-1:0] :
                                                     REL_SLOW_CYC[REL_W-1:0];
  always @(posedge CLK) begin
    if (RST) begin
      irq_low_r <= 1'b0;
      rel_cnt_r <= {REL_W{1'b0}};
    end else if (!run || !timer_irq_enable) begin
      irq_low_r <= 1'b0;
      rel_cnt_r <= {REL_W{1'b0}};
    end else if (timer_evt) begin
      irq_low_r <= 1'b1;
      rel_cnt_r <= rel_len - {{(REL_W-1){1'b0}}, 1'b1};
    end else if (irq_low_r) begin
      if (rel_cnt_r == {REL_W{1'b0}})
        irq_low_r <= 1'b0;
      else
        rel_cnt_r <= rel_cnt_r - {{(REL_W-1){1'b0}}, 1'b1};
    end
  end

  // Open-drain pin; flag state does not feed it
  always @(posedge CLK) begin
    if (RST) begin
      INT_N_O <= 1'b0;
      INT_N_OE <= 1'b0;
    end else begin
      INT_N_O <= 1'b0;
      INT_N_OE <= irq_low_r & run & timer_irq_enable;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  // Write fires once address and data are both held and no response waits
  wire do_wr = aw_have_r & w_have_r & ~S_AXI_BVALID;
  wire [`FCT_ADDR_W-1:0] wa = aw_addr_r;
  wire wr_lane = w_strb_r[0];
  wire [7:0] wd = w_data_r[7:0];
  wire wr_hit = (wa == {`FCT_IDX_PRESET_LO, 2'b00}) || (wa == {`FCT_IDX_PRESET_HI, 2'b00}) ||
                (wa == {`FCT_IDX_EXT_CFG, 2'b00}) || (wa == {`FCT_IDX_FLAGS, 2'b00}) ||
                (wa == {`FCT_IDX_IRQ_CTRL, 2'b00}) || (wa == {`FCT_IDX_EVT_CTRL, 2'b00}) ||
                (wa == {`FCT_IDX_CAP_HUND, 2'b00}) || (wa == {`FCT_IDX_CAP_SEC, 2'b00});

  // Address and data accepted in either order; response after both
  always @(posedge CLK) begin
    if (RST) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= {`FCT_ADDR_W{1'b0}};
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `FCT_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? `FCT_RESP_OKAY : `FCT_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  // Only byte lane 0 carries register data; event reset waits for a pin edge
  wire wr_en = do_wr & wr_lane;
  wire evt_rst_fire = evt_ctrl_r[`FCT_EVT_SUBRST] & evt_seen;

  // Stored fields; hardware sets win over software clears
  always @(posedge CLK) begin
    if (RST) begin
      preset_lo_r <= 8'h00;
      preset_hi_r <= 8'h00;
      ext_cfg_r <= 8'h00;
      flags_r <= 8'h00;
      ctrl_r <= 8'h00;
      evt_ctrl_r <= 8'h00;
    end else begin
      if (wr_en && wa == {`FCT_IDX_PRESET_LO, 2'b00})
        preset_lo_r <= wd;
      if (wr_en && wa == {`FCT_IDX_PRESET_HI, 2'b00})
        preset_hi_r <= wd;
      if (wr_en && wa == {`FCT_IDX_EXT_CFG, 2'b00})
        ext_cfg_r <= wd;
      if (wr_en && wa == {`FCT_IDX_IRQ_CTRL, 2'b00})
        ctrl_r <= wd & `FCT_CTL_MASK;
      else if (clk_rst && !ce_s2_r)
        ctrl_r[`FCT_CTL_CLKRST] <= 1'b0;
      if (wr_en && wa == {`FCT_IDX_FLAGS, 2'b00})
        flags_r <= flags_r & wd & `FCT_FLG_MASK;
      if (timer_evt)
        flags_r[`FCT_FLG_TEVT] <= 1'b1;
      if (wr_en && wa == {`FCT_IDX_EVT_CTRL, 2'b00})
        evt_ctrl_r <= wd & `FCT_EVT_MASK;
      if (evt_rst_fire)
        evt_ctrl_r[`FCT_EVT_SUBRST] <= 1'b0;
    end
  end

  // Capture registers, zeroed by the event-synchronised reset
  always @(posedge CLK) begin
    if (RST) begin
      cap_hund_r <= 8'h00;
      cap_sec_r <= 8'h00;
    end else if (evt_rst_fire) begin
      cap_hund_r <= 8'h00;
      cap_sec_r <= 8'h00;
    end else if (CAP_LOAD) begin
      cap_hund_r <= CAP_HUND_IN;
      cap_sec_r <= CAP_SEC_IN & `FCT_SEC_MASK;
    end
  end

  // Sub-second clear and timekeeping halt toward the calendar core
  always @(posedge CLK) begin
    if (RST) begin
      SUBSEC_CLR <= 1'b0;
      CLOCK_HALT <= 1'b0;
    end else begin
      SUBSEC_CLR <= clk_rst | evt_rst_fire;
      CLOCK_HALT <= clk_rst;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  // Read decode; unmapped addresses return zero with an error response
  reg [7:0] rd_byte;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    if (S_AXI_ARADDR == {`FCT_IDX_PRESET_LO, 2'b00})
      rd_byte = preset_lo_r;
    else if (S_AXI_ARADDR == {`FCT_IDX_PRESET_HI, 2'b00})
      rd_byte = preset_hi_r;
    else if (S_AXI_ARADDR == {`FCT_IDX_EXT_CFG, 2'b00})
      rd_byte = ext_cfg_r;
    else if (S_AXI_ARADDR == {`FCT_IDX_FLAGS, 2'b00})
      rd_byte = flags_r;
    else if (S_AXI_ARADDR == {`FCT_IDX_IRQ_CTRL, 2'b00})
      rd_byte = ctrl_r;
    else if (S_AXI_ARADDR == {`FCT_IDX_CAP_HUND, 2'b00})
      rd_byte = cap_hund_r;
    else if (S_AXI_ARADDR == {`FCT_IDX_CAP_SEC, 2'b00})
      rd_byte = cap_sec_r;
    else if (S_AXI_ARADDR == {`FCT_IDX_EVT_CTRL, 2'b00})
      rd_byte = evt_ctrl_r;
    else begin
      rd_byte = 8'h00;
      rd_hit = 1'b0;
    end
  end

  // One read at a time; data one cycle after address taken
  always @(posedge CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `FCT_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h000000, rd_byte};
      S_AXI_RRESP <= rd_hit ? `FCT_RESP_OKAY : `FCT_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule // fct_timer

// *** testbench/fct_irq_host.sv ***
// Host-side model of the shared open-drain interrupt wire.
// Assumes the timer only ever pulls the pin low through its enable.
`timescale 1ns/1ps
module fct_irq_host (
  input wire int_n_o,
  input wire int_n_oe,
  output wire int_line
);
  // Pull-up holds the wire high whenever nobody drives it
  assign int_line = int_n_oe ? int_n_o : 1'b1;
endmodule // fct_irq_host

// *** testbench/fct_timer_assertions.sv ***
// Port-level checker for the fixed-cycle timer.
// Assumes it is bound into fct_timer; one clock, synchronous reset.
`timescale 1ns/1ps
module fct_chk #(
  parameter REL_SLOW_CYC = 20
) (
  input wire CLK,
  input wire RST,
  input wire TICK_4096,
  input wire TICK_64,
  input wire TICK_SEC,
  input wire TICK_MIN,
  input wire CE_PIN,
  input wire INT_N_O,
  input wire INT_N_OE,
  input wire SUBSEC_CLR,
  input wire CLOCK_HALT,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  // Counts cycles the interrupt pin has been pulled low
  int low_cnt_r;
  always @(posedge CLK) begin
    if (RST || !INT_N_OE)
      low_cnt_r <= 0;
    else
      low_cnt_r <= low_cnt_r + 1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  int_drive_a: assert property (INT_N_OE |-> !INT_N_O)
    else $error("interrupt pin driven high");
  int_cause_a: assert property ($rose(INT_N_OE) |->
    $past(TICK_4096 || TICK_64 || TICK_SEC || TICK_MIN, 2))
    else $error("interrupt without a source tick");
  int_release_a: assert property (low_cnt_r <= REL_SLOW_CYC + 2)
    else $error("interrupt not released in time");
  halt_clear_a: assert property (CLOCK_HALT |-> SUBSEC_CLR)
    else $error("halt without subsecond clear");
  halt_release_a: assert property ($fell(CLOCK_HALT) |->
    !$past(CE_PIN, 2) || !$past(CE_PIN, 3) || !$past(CE_PIN, 4))
    else $error("halt released while chip enable high");
  rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID)
    else $error("read not answered");
  rd_busy_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address accepted while busy");
  rd_done_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read data held after handshake");
  wr_busy_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while response pending");
  wr_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response held after handshake");
endmodule // fct_chk

bind fct_timer fct_chk #(.REL_SLOW_CYC(REL_SLOW_CYC)) u_fct_chk (.CLK(CLK), .RST(RST),
  .TICK_4096(TICK_4096), .TICK_64(TICK_64), .TICK_SEC(TICK_SEC), .TICK_MIN(TICK_MIN),
  .CE_PIN(CE_PIN), .INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE), .SUBSEC_CLR(SUBSEC_CLR),
  .CLOCK_HALT(CLOCK_HALT), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// *** testbench/testbench.sv ***
// Self-checking bench: AXI4-Lite register traffic, source ticks and pins.
// Assumes shortened release times of 5 and 40 cycles.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  localparam logic [9:0] PLO = 10'h02C, PHI = 10'h030, EXT = 10'h034, FLG = 10'h038;
  localparam logic [9:0] CTL = 10'h03C, CHU = 10'h080, CSE = 10'h084, EVT = 10'h0BC;
  logic clk = 0, rst = 1, ce = 1, evp = 0, capl = 0;
  logic awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
  logic [3:0] tick = 4'h0;
  logic [9:0] awa = 10'h000, ara = 10'h000;
  logic [31:0] wd = 32'h0;
  logic [1:0] br, rr;
  wire io, ioe, sclr, halt, awr, wr_rdy, bv, arr, rv, int_line;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int num_errors = 0, n_compared = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  fct_timer #(.REL_FAST_CYC(5), .REL_SLOW_CYC(40)) i_fct_timer (.CLK(clk), .RST(rst),
    .TICK_4096(tick[0]), .TICK_64(tick[1]), .TICK_SEC(tick[2]), .TICK_MIN(tick[3]),
    .CE_PIN(ce), .EVENT_PIN(evp), .CAP_HUND_IN(8'hAA), .CAP_SEC_IN(8'hD5), .CAP_LOAD(capl),
    .INT_N_O(io), .INT_N_OE(ioe), .SUBSEC_CLR(sclr), .CLOCK_HALT(halt),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rrd));
  fct_irq_host i_fct_irq_host (.int_n_o(io), .int_n_oe(ioe), .int_line(int_line));
  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  task report_and_stop;
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    brd <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr_rdy) wv <= 0;
      ad |= awr;
      dd |= wr_rdy;
    end while (!(ad && dd));
    do @(posedge clk); while (!bv);
    br = bresp;
    brd <= 0;
  endtask
  task rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rrd <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    do @(posedge clk); while (!rv);
    rrd <= 0;
    rr = rresp;
    `CHK(rdata, {24'h0, e})
  endtask
  task tk(input int s, input int n);
    repeat (n) begin
      @(posedge clk);
      tick[s] <= 1;
      @(posedge clk);
      tick[s] <= 0;
    end
  endtask
  task pin(input int c, input logic e);
    repeat (c) @(posedge clk);
    `CHK(int_line, e)
  endtask
  task ev(input logic [3:0] n);
    logic [3:0] c;
    c = 4'h0;
    @(posedge clk);
    evp <= 1;
    repeat (6) begin
      @(posedge clk);
      c = c + {3'h0, sclr};
    end
    evp <= 0;
    repeat (6) begin
      @(posedge clk);
      c = c + {3'h0, sclr};
    end
    `CHK(c, n)
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    capl <= 1;
    wr(PLO, 8'hA5);
    capl <= 0;
    rd(PLO, 8'hA5);
    `CHK({br, rr}, 4'h0)
    wr(PHI, 8'hF3);
    rd(PHI, 8'hF3);
    wr(CTL, 8'hFF);
    rd(CTL, 8'hFD);
    `CHK({halt, sclr}, 2'h3)
    ce <= 0;
    repeat (8) @(posedge clk);
    ce <= 1;
    rd(CTL, 8'hFC);
    wr(EVT, 8'hFF);
    rd(EVT, 8'hF1);
    wr(EVT, 8'h00);
    ev(4'h0);
    rd(CHU, 8'hAA);
    rd(CSE, 8'h55);
    wr(EVT, 8'h01);
    ev(4'h1);
    rd(EVT, 8'h00);
    rd(CHU, 8'h00);
    rd(CSE, 8'h00);
    wr(CTL, 8'h00);
    wr(PHI, 8'h00);
    wr(PLO, 8'h03);
    wr(CTL, 8'h10);
    wr(EXT, 8'h11);
    tk(0, 3);
    rd(FLG, 8'h00);
    tk(1, 3);
    pin(3, 1'b0);
    rd(FLG, 8'h10);
    wr(FLG, 8'h00);
    pin(1, 1'b0);
    wr(FLG, 8'h10);
    rd(FLG, 8'h00);
    wr(CTL, 8'h00);
    pin(3, 1'b1);
    tk(1, 3);
    pin(3, 1'b1);
    wr(CTL, 8'h10);
    wr(FLG, 8'h00);
    tk(1, 3);
    pin(3, 1'b0);
    wr(EXT, 8'h00);
    pin(3, 1'b1);
    wr(FLG, 8'h00);
    wr(EXT, 8'h11);
    tk(1, 2);
    wr(EXT, 8'h00);
    wr(EXT, 8'h11);
    tk(1, 2);
    rd(FLG, 8'h00);
    tk(1, 1);
    rd(FLG, 8'h10);
    wr(EXT, 8'h00);
    wr(EXT, 8'h10);
    tk(0, 3);
    pin(3, 1'b0);
    pin(3, 1'b0);
    pin(1, 1'b1);
    for (int s = 2; s < 4; s++) begin
      wr(EXT, 8'h00);
      wr(FLG, 8'h00);
      wr(EXT, 8'h10 + 8'(s));
      tk(0, 2);
      tk(s, 2);
      rd(FLG, 8'h00);
      tk(s, 1);
      rd(FLG, 8'h10);
    end
    wr(EXT, 8'h00);
    wr(FLG, 8'h00);
    wr(CTL, 8'h01);
    wr(EXT, 8'h11);
    tk(1, 3);
    rd(FLG, 8'h00);
    wr(EXT, 8'h00);
    wr(EXT, 8'h10);
    tk(0, 3);
    rd(FLG, 8'h10);
    ce <= 0;
    repeat (8) @(posedge clk);
    `CHK(halt, 1'b0)
    wr(10'h3F0, 8'h5A);
    `CHK(br, 2'h2)
    rd(10'h3F0, 8'h00);
    `CHK(rr, 2'h2)
    report_and_stop();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule // testbench
